/* File: core/cvr_top.sv */
// Comparator reference control with comparator status, AHB-Lite slave
//
// Implementation choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ns
module cvr_top
	import cvr_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	input  wire logic        cmp1_out_pin,
	input  wire logic        cmp2_out_pin,
	input  wire logic        idle_mode,
	output logic             comparators_enable,
	output logic             ladder_enable,
	output logic             reference_pin_output_enable,
	output logic             reference_range_select,
	output logic             reference_source_select,
	output logic      [3:0]  reference_tap_value,
	output logic      [6:0]  ladder_reference_level
);
	logic [31:0]        ctrl_r;
	logic [31:0]        ctrl_nxt;
	logic [31:0]        stat_r;
	logic [31:0]        stat_nxt;
	logic               wr_pend_r;
	logic [31:0]        wr_addr_r;
	logic               hreadyout_r;
	logic               hresp_r;
	logic [31:0]        hrdata_r;
	logic [CVR_NCMP-1:0] sync1_r;
	logic [CVR_NCMP-1:0] sync2_r;
	logic               cmp_en_r;
	logic               ladder_en_r;
	logic               pin_oe_r;
	logic               range_r;
	logic               src_r;
	logic [3:0]         tap_r;
	logic               take;
	logic [CVR_NCMP-1:0] cmp_pins;
	cvr_cfg_if          cfg();

	// Offset within a register's alias group selects the operation
	function automatic cvr_op_t alias_op(input logic [31:0] a);
		logic [3:0] low;
		low = a[3:0];
		case (low)
			CVR_OFF_CLR[3:0]: alias_op = CVR_OP_CLR;
			CVR_OFF_SET[3:0]: alias_op = CVR_OP_SET;
			CVR_OFF_INV[3:0]: alias_op = CVR_OP_INV;
			default:          alias_op = CVR_OP_WRITE;
		endcase
	endfunction : alias_op

	function automatic logic [31:0] alias_apply(
		input logic [31:0] old,
		input logic [31:0] d,
		input logic [31:0] mask,
		input cvr_op_t     op
	);
		logic [31:0] dm;
		dm = d & mask;
		case (op)
			CVR_OP_CLR: alias_apply = old & ~dm;
			CVR_OP_SET: alias_apply = old | dm;
			CVR_OP_INV: alias_apply = old ^ dm;
			default:    alias_apply = dm;
		endcase
	endfunction : alias_apply

	// Address phase is taken only for whole-word transfers
	assign take = hsel && hready && htrans == CVR_HTRANS_NSEQ
		&& hsize == CVR_HSIZE_WORD;

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 32'h0000_0000;
		end else begin
			wr_pend_r <= take && hwrite;
			wr_addr_r <= haddr;
		end
	end

	// Zero-wait slave, always OKAY
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			hreadyout_r <= 1'b0;
			hresp_r     <= 1'b0;
		end else begin
			hreadyout_r <= 1'b1;
			hresp_r     <= 1'b0;
		end
	end

	always_comb begin
		ctrl_nxt = ctrl_r;
		stat_nxt = stat_r;
		if (wr_pend_r) begin
			if (wr_addr_r[31:4] == CVR_OFF_CTRL[31:4]) begin
				// Enable and settings change independently
				ctrl_nxt = alias_apply(ctrl_r, hwdata, CVR_CTRL_MASK,
					alias_op(wr_addr_r));
			end
			if (wr_addr_r[31:4] == CVR_OFF_STAT[31:4]) begin
				stat_nxt = alias_apply(stat_r, hwdata, CVR_STAT_WMASK,
					alias_op(wr_addr_r));
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			ctrl_r <= CVR_CTRL_RST;
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			stat_r <= CVR_STAT_RST;
		end else begin
			stat_r <= stat_nxt;
		end
	end

	// Comparator outputs arrive from the analog side
	assign cmp_pins = {cmp2_out_pin, cmp1_out_pin};

	generate
		for (genvar i = 0; i < CVR_NCMP; i++) begin : g_sync
			always_ff @(posedge core_clk) begin
				if (!nrst) begin
					sync1_r[i] <= 1'b0;
					sync2_r[i] <= 1'b0;
				end else begin
					sync1_r[i] <= cmp_pins[i];
					sync2_r[i] <= sync1_r[i];
				end
			end
		end
	endgenerate

	// Read data taken from next values so a write just before is seen
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			hrdata_r <= 32'h0000_0000;
		end else if (take && !hwrite) begin
			if (haddr == CVR_OFF_CTRL) begin
				hrdata_r <= ctrl_nxt & CVR_CTRL_MASK;
			end else if (haddr == CVR_OFF_STAT) begin
				hrdata_r <= (stat_nxt & CVR_STAT_WMASK)
					| {30'h0000_0000, sync2_r};
			end else begin
				hrdata_r <= 32'h0000_0000;
			end
		end else begin
			hrdata_r <= 32'h0000_0000;
		end
	end

	// Comparators run unless stopped for idle
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			cmp_en_r <= 1'b1;
		end else begin
			cmp_en_r <= !(stat_nxt[CVR_BIT_STOP_IN_IDLE] && idle_mode);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			ladder_en_r <= 1'b0;
			pin_oe_r    <= 1'b0;
			range_r     <= 1'b0;
			src_r       <= 1'b0;
			tap_r       <= 4'h0;
		end else begin
			ladder_en_r <= ctrl_nxt[CVR_BIT_ON];
			pin_oe_r    <= ctrl_nxt[CVR_BIT_OE];
			range_r     <= ctrl_nxt[CVR_BIT_RANGE];
			src_r       <= ctrl_nxt[CVR_BIT_SRC];
			tap_r       <= ctrl_nxt[CVR_TAP_MSB:0];
		end
	end

	assign cfg.enable    = ladder_en_r;
	assign cfg.range_sel = range_r;
	assign cfg.tap       = tap_r;

	cvr_ladder u_ladder (
		.core_clk (core_clk),
		.nrst     (nrst),
		.cfg      (cfg)
	);

	assign hreadyout                   = hreadyout_r;
	assign hresp                       = hresp_r;
	assign hrdata                      = hrdata_r;
	assign comparators_enable          = cmp_en_r;
	assign ladder_enable               = ladder_en_r;
	assign reference_pin_output_enable = pin_oe_r;
	assign reference_range_select      = range_r;
	assign reference_source_select     = src_r;
	assign reference_tap_value         = tap_r;
	assign ladder_reference_level      = cfg.level;

	// Whole-word write: address phase, then its data phase
	sequence ctrl_write_s(logic [31:0] a);
		take && hwrite && haddr == a ##1 wr_pend_r;
	endsequence

	// Same two steps aimed at the status register group
	sequence stat_write_s(logic [31:0] a);
		take && hwrite && haddr == a ##1 wr_pend_r;
	endsequence

	// Whole-word read address phase; data stands in the next cycle
	sequence word_read_s(logic [31:0] a);
		take && !hwrite && haddr == a;
	endsequence

	// Bus answers
	ready_always_a: assert property (@(posedge core_clk) disable iff (!nrst)
		$past(nrst) |-> hreadyout && !hresp)
		else $error("slave not ready or error");
	read_stands_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		!($past(take) && !$past(hwrite)) |-> hrdata == 32'h0000_0000)
		else $error("read data outside data phase");
	narrow_ignored_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		hsel && hready && htrans == CVR_HTRANS_NSEQ && hwrite
		&& hsize != CVR_HSIZE_WORD
		|=> !wr_pend_r ##1 ctrl_r == $past(ctrl_r))
		else $error("narrow write applied");

	// Control register and its aliases
	base_write_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		ctrl_write_s(CVR_OFF_CTRL)
		|=> ctrl_r == ($past(hwdata) & CVR_CTRL_MASK))
		else $error("base write wrong");
	set_alias_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		ctrl_write_s(CVR_OFF_CTRL | CVR_OFF_SET)
		|=> ctrl_r == ($past(ctrl_r) | ($past(hwdata) & CVR_CTRL_MASK)))
		else $error("set alias wrong");
	clr_alias_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		ctrl_write_s(CVR_OFF_CTRL | CVR_OFF_CLR)
		|=> ctrl_r == ($past(ctrl_r) & ~($past(hwdata) & CVR_CTRL_MASK)))
		else $error("clear alias wrong");
	inv_alias_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		ctrl_write_s(CVR_OFF_CTRL | CVR_OFF_INV)
		|=> ctrl_r == ($past(ctrl_r) ^ ($past(hwdata) & CVR_CTRL_MASK)))
		else $error("invert alias wrong");
	enable_keeps_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		ctrl_write_s(CVR_OFF_CTRL | CVR_OFF_SET) ##0 hwdata == 32'h0000_8000
		|=> ctrl_r[CVR_BIT_ON] && ctrl_r[6:0] == $past(ctrl_r[6:0])
		##1 ladder_enable)
		else $error("enable disturbed settings");
	enable_clear_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		ctrl_write_s(CVR_OFF_CTRL | CVR_OFF_CLR) ##0 hwdata == 32'h0000_8000
		|=> !ctrl_r[CVR_BIT_ON] && ctrl_r[6:0] == $past(ctrl_r[6:0])
		&& !ladder_enable)
		else $error("disable disturbed settings");
	ctrl_read_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		word_read_s(CVR_OFF_CTRL)
		|=> (hrdata & ~CVR_CTRL_MASK) == 32'h0000_0000)
		else $error("control read shows reserved bits");
	alias_read_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		word_read_s(CVR_OFF_CTRL | CVR_OFF_SET) |=> hrdata == 32'h0000_0000)
		else $error("alias read nonzero");
	reserved_zero_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		(hrdata & ~(CVR_CTRL_MASK | CVR_STAT_WMASK | 32'h0000_0003)) == 0)
		else $error("reserved bits read nonzero");

	// Ladder controls mirror the stored bits from the write edge on
	enable_follow_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		$past(nrst) |-> ladder_enable == ctrl_r[CVR_BIT_ON])
		else $error("enable output differs from register");
	pin_oe_follow_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		$past(nrst) |-> reference_pin_output_enable == ctrl_r[CVR_BIT_OE])
		else $error("pin enable output differs from register");
	range_follow_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		$past(nrst) |-> reference_range_select == ctrl_r[CVR_BIT_RANGE])
		else $error("range output differs from register");
	source_follow_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		$past(nrst) |-> reference_source_select == ctrl_r[CVR_BIT_SRC])
		else $error("source output differs from register");
	tap_follow_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		$past(nrst) |-> reference_tap_value == ctrl_r[CVR_TAP_MSB:0])
		else $error("tap output differs from register");
	outputs_follow_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		ctrl_write_s(CVR_OFF_CTRL)
		|=> ##1 reference_tap_value == $past(ctrl_r[3:0])
		&& reference_pin_output_enable == $past(ctrl_r[CVR_BIT_OE])
		&& reference_source_select == $past(ctrl_r[CVR_BIT_SRC]))
		else $error("control outputs lag");

	// Status register, its aliases and the comparator enable
	status_write_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		stat_write_s(CVR_OFF_STAT)
		|=> stat_r == ($past(hwdata) & CVR_STAT_WMASK))
		else $error("status write wrong");
	stat_set_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		stat_write_s(CVR_OFF_STAT | CVR_OFF_SET)
		|=> stat_r == ($past(stat_r) | ($past(hwdata) & CVR_STAT_WMASK)))
		else $error("status set alias wrong");
	stat_clr_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		stat_write_s(CVR_OFF_STAT | CVR_OFF_CLR)
		|=> stat_r == ($past(stat_r) & ~($past(hwdata) & CVR_STAT_WMASK)))
		else $error("status clear alias wrong");
	stat_inv_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		stat_write_s(CVR_OFF_STAT | CVR_OFF_INV)
		|=> stat_r == ($past(stat_r) ^ ($past(hwdata) & CVR_STAT_WMASK)))
		else $error("status invert alias wrong");
	stat_read_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		word_read_s(CVR_OFF_STAT)
		|=> (hrdata & ~(CVR_STAT_WMASK | 32'h0000_0003)) == 32'h0000_0000)
		else $error("status read shows reserved bits");
	status_follow_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		word_read_s(CVR_OFF_STAT) |=> hrdata[1:0] == $past(sync2_r))
		else $error("status not tracking comparators");
	idle_stop_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		$past(stat_r[CVR_BIT_STOP_IN_IDLE]) && stat_r[CVR_BIT_STOP_IN_IDLE] && $past(idle_mode)
		|-> !comparators_enable)
		else $error("comparators run in idle");
	cmp_run_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		!stat_r[CVR_BIT_STOP_IN_IDLE] || !$past(idle_mode) |-> comparators_enable)
		else $error("comparators stopped outside idle stop");
endmodule : cvr_top

/* File: shared/cvr_pkg.sv */
// Constants, offsets and field layout of the comparator reference control
// Contract
// - Enable bit 15 set leaves other bits
// - Enable clear powers down, keeps settings
// - Bit 6 connects reference to pin
// - Range 1: tap/24 of span
// - Bit 4 selects external or supply span
// - Tap field bits 3..0, sixteen levels
// - Unimplemented bits read as zero
// - Clear, set, invert aliases at +4,+8,+C
// - Stop-in-idle bit 13 halts comparators
// - Status bit 1 shows comparator two
// - Status bit 0 shows comparator one
// - Sixteen-tap ladder, two ranges, internal route
package cvr_pkg;
	localparam logic [31:0] CVR_OFF_STAT     = 32'h0000_0000;
	localparam logic [31:0] CVR_OFF_CTRL     = 32'h0000_0010;
	localparam logic [31:0] CVR_OFF_CLR      = 32'h0000_0004;
	localparam logic [31:0] CVR_OFF_SET      = 32'h0000_0008;
	localparam logic [31:0] CVR_OFF_INV      = 32'h0000_000C;
	localparam logic [31:0] CVR_CTRL_MASK    = 32'h0000_807F;
	localparam logic [31:0] CVR_STAT_WMASK   = 32'h0000_2000;
	localparam logic [31:0] CVR_CTRL_RST     = 32'h0000_0000;
	localparam logic [31:0] CVR_STAT_RST     = 32'h0000_0000;
	localparam int          CVR_BIT_ON       = 15;
	localparam int          CVR_BIT_OE       = 6;
	localparam int          CVR_BIT_RANGE    = 5;
	localparam int          CVR_BIT_SRC      = 4;
	localparam int          CVR_TAP_MSB      = 3;
	localparam int          CVR_BIT_STOP_IN_IDLE     = 13;
	localparam int          CVR_BIT_C2       = 1;
	localparam int          CVR_BIT_C1       = 0;
	localparam int          CVR_NCMP         = 2;
	localparam int          CVR_LVL_W        = 7;
	localparam logic [6:0]  CVR_LVL_DEN      = 7'h60;
	localparam logic [6:0]  CVR_LOW_BASE     = 7'h18;
	localparam logic [6:0]  CVR_LOW_STEP     = 7'h03;
	localparam logic [6:0]  CVR_HIGH_STEP    = 7'h04;
	localparam logic [1:0]  CVR_HTRANS_NSEQ  = 2'h2;
	localparam logic [2:0]  CVR_HSIZE_WORD   = 3'h2;
	typedef enum logic [1:0] {
		CVR_OP_WRITE,
		CVR_OP_CLR,
		CVR_OP_SET,
		CVR_OP_INV
	} cvr_op_t;
endpackage : cvr_pkg

/* File: shared/cvr_cfg_if.sv */
// Ladder configuration carried from the register file to the ladder control
`timescale 1ns/1ns
interface cvr_cfg_if;
	logic       enable;
	logic       range_sel;
	logic [3:0] tap;
	logic [6:0] level;
	modport regs (
		output enable,
		output range_sel,
		output tap,
		input  level
	);
	modport ladder (
		input  enable,
		input  range_sel,
		input  tap,
		output level
	);
endinterface : cvr_cfg_if

/* File: core/cvr_ladder.sv */
// Ladder control: reference level in 96ths of the source span
`timescale 1ns/1ns
module cvr_ladder
	import cvr_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic nrst,
	cvr_cfg_if.ladder cfg
);
	logic [6:0] level_r;
	logic [6:0] level_nxt;

	always_comb begin
		level_nxt = 7'h00;
		if (cfg.enable) begin
			if (cfg.range_sel) begin
				level_nxt = 7'({3'h0, cfg.tap} * CVR_HIGH_STEP);
			end else begin
				level_nxt = 7'(CVR_LOW_BASE
					+ {3'h0, cfg.tap} * CVR_LOW_STEP);
			end
		end
	end

	// Disabled ladder carries no level
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			level_r <= 7'h00;
		end else begin
			level_r <= level_nxt;
		end
	end

	assign cfg.level = level_r;

	high_range_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		$past(cfg.enable) && $past(cfg.range_sel)
		|-> level_r == {$past(cfg.tap), 2'b00} && level_r <= 7'h3C)
		else $error("high range level wrong");
	low_range_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		$past(cfg.enable) && !$past(cfg.range_sel)
		|-> level_r >= 7'h18 && level_r <= 7'h45
		&& level_r - 7'h18 == 7'($past(cfg.tap) * 3))
		else $error("low range level wrong");
	ladder_off_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		!$past(cfg.enable) |-> level_r == 7'h00)
		else $error("level present while off");
endmodule : cvr_ladder

/* File: dv/tb_top.sv */
// Self-checking bench for the comparator reference control block
`timescale 1ns/1ns
module tb_top
	import cvr_pkg::*;
;
	typedef struct packed {
		logic [31:0] a;
		logic [31:0] d;
		logic [31:0] e;
	} cvr_row_t;

	logic        core_clk;
	logic        nrst;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        cmp1_out_pin;
	logic        cmp2_out_pin;
	logic        idle_mode;
	logic        comparators_enable;
	logic        ladder_enable;
	logic        reference_pin_output_enable;
	logic        reference_range_select;
	logic        reference_source_select;
	logic [3:0]  reference_tap_value;
	logic [6:0]  ladder_reference_level;
	int          error_cnt;
	int          check_count;
	logic [31:0] ctl;
	// Base and alias writes, each followed by the expected control readback
	cvr_row_t    rows [8] = '{
		'{CVR_OFF_CTRL, 32'hFFFF_FFFF, 32'h0000_807F},
		'{CVR_OFF_CTRL + CVR_OFF_CLR, 32'h0000_8000, 32'h0000_007F},
		'{CVR_OFF_CTRL + CVR_OFF_SET, 32'h0000_8000, 32'h0000_807F},
		'{CVR_OFF_CTRL + CVR_OFF_INV, 32'h0000_0020, 32'h0000_805F},
		'{CVR_OFF_CTRL + CVR_OFF_CLR, 32'h0000_000F, 32'h0000_8050},
		'{CVR_OFF_CTRL + CVR_OFF_SET, 32'h0000_0025, 32'h0000_8075},
		'{CVR_OFF_CTRL + CVR_OFF_INV, 32'h0000_0050, 32'h0000_8025},
		'{CVR_OFF_CTRL, 32'h0000_0000, 32'h0000_0000}
	};

	cvr_top dut_u (
		.core_clk                    (core_clk),
		.nrst                        (nrst),
		.hsel                        (hsel),
		.haddr                       (haddr),
		.htrans                      (htrans),
		.hwrite                      (hwrite),
		.hsize                       (hsize),
		.hwdata                      (hwdata),
		.hready                      (hreadyout),
		.hreadyout                   (hreadyout),
		.hresp                       (hresp),
		.hrdata                      (hrdata),
		.cmp1_out_pin                (cmp1_out_pin),
		.cmp2_out_pin                (cmp2_out_pin),
		.idle_mode                   (idle_mode),
		.comparators_enable          (comparators_enable),
		.ladder_enable               (ladder_enable),
		.reference_pin_output_enable (reference_pin_output_enable),
		.reference_range_select      (reference_range_select),
		.reference_source_select     (reference_source_select),
		.reference_tap_value         (reference_tap_value),
		.ladder_reference_level      (ladder_reference_level)
	);

	always #5 core_clk = ~core_clk;

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [31:0] g, input logic [31:0] e,
			input string m);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : chk

	// Bounded wait for hready; read data is taken at the same edge
	task automatic wait_rdy(output logic [31:0] rd);
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		rd = hrdata;
		if (hreadyout !== 1'b1) begin
			error_cnt++;
			$display("[ERR] %0t hready timeout", $time);
			tally_and_finish();
		end
	endtask : wait_rdy

	task automatic xfer(input logic wr, input logic [2:0] sz,
			input logic [31:0] a, input logic [31:0] d,
			output logic [31:0] rd);
		logic [31:0] nul;
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= CVR_HTRANS_NSEQ;
		hwrite <= wr;
		hsize  <= sz;
		wait_rdy(nul);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wr ? d : 32'h0000_0000;
		wait_rdy(rd);
		chk(32'(hresp), 32'h0000_0000, "response");
	endtask : xfer

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] nul;
		xfer(1'b1, CVR_HSIZE_WORD, a, d, nul);
	endtask : wr

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] e,
			input string m);
		logic [31:0] r;
		xfer(1'b0, CVR_HSIZE_WORD, a, 32'h0000_0000, r);
		chk(r, e, m);
	endtask : rd_chk

	function automatic logic [6:0] lvl(input logic [31:0] c);
		if (!c[15])
			return 7'h00;
		if (c[5])
			return {3'h0, c[3:0]} * CVR_HIGH_STEP;
		return CVR_LOW_BASE + {3'h0, c[3:0]} * CVR_LOW_STEP;
	endfunction : lvl

	initial begin
		{core_clk, nrst, hsel, hwrite, idle_mode} = '0;
		{cmp1_out_pin, cmp2_out_pin, htrans, hsize} = '0;
		{haddr, hwdata, error_cnt, check_count} = '0;
		repeat (10) @(posedge core_clk);
		chk(32'(comparators_enable), 32'h0000_0001, "cmp en rst");
		chk(32'(hreadyout), 32'h0000_0000, "ready in reset");
		nrst <= 1'b1;
		@(posedge core_clk);
		rd_chk(CVR_OFF_CTRL, CVR_CTRL_RST, "ctrl reset");
		rd_chk(CVR_OFF_STAT, CVR_STAT_RST, "stat reset");
		$display("reset test done");
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			if (!rows[i].e[CVR_BIT_ON]) @(posedge core_clk);
			rd_chk(CVR_OFF_CTRL, rows[i].e, "ctrl readback");
			repeat (4) @(posedge core_clk);
			ctl = {16'h0000, ladder_enable, 8'h00, reference_pin_output_enable,
				reference_range_select, reference_source_select,
				reference_tap_value};
			chk(ctl, rows[i].e, "ladder controls");
			chk(32'(ladder_reference_level), 32'(lvl(rows[i].e)), "level");
		end
		$display("control table test done");
		cmp1_out_pin <= 1'b1;
		wr(CVR_OFF_STAT, 32'hFFFF_FFFF);
		rd_chk(CVR_OFF_STAT, 32'h0000_2001, "stat c1");
		idle_mode <= 1'b1;
		{cmp1_out_pin, cmp2_out_pin} <= 2'b01;
		repeat (4) @(posedge core_clk);
		chk(32'(comparators_enable), 32'h0000_0000, "stop in idle");
		rd_chk(CVR_OFF_STAT, 32'h0000_2002, "stat c2");
		wr(CVR_OFF_STAT + CVR_OFF_INV, 32'hFFFF_FFFF);
		rd_chk(CVR_OFF_STAT, 32'h0000_0002, "stat inverted");
		wr(CVR_OFF_STAT + CVR_OFF_SET, 32'h0000_2000);
		rd_chk(CVR_OFF_STAT, 32'h0000_2002, "stat set");
		wr(CVR_OFF_STAT + CVR_OFF_CLR, 32'h0000_2000);
		repeat (2) @(posedge core_clk);
		chk(32'(comparators_enable), 32'h0000_0001, "run in idle");
		rd_chk(CVR_OFF_STAT, 32'h0000_0002, "stat cleared");
		$display("status test done");
		wr(CVR_OFF_CTRL, 32'h0000_0043);
		xfer(1'b1, 3'h0, CVR_OFF_CTRL, 32'hFFFF_FFFF, ctl);
		wr(32'h0000_0040, 32'hFFFF_FFFF);
		rd_chk(CVR_OFF_CTRL, 32'h0000_0043, "ignored writes");
		rd_chk(CVR_OFF_CTRL + CVR_OFF_SET, 32'h0000_0000, "alias read");
		rd_chk(32'h0000_0020, 32'h0000_0000, "unmapped read");
		$display("refusal test done");
		nrst <= 1'b0;
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		rd_chk(CVR_OFF_CTRL, CVR_CTRL_RST, "ctrl after reset");
		$display("mid-run reset test done");
		tally_and_finish();
	end
endmodule : tb_top
